// File: hdl/wdr_pkg.sv
// Package of constants and types for the watchdog reset timer
`default_nettype none

package wdr_pkg;

    // ---------------------------------------------------------------
    // Register map
    // ---------------------------------------------------------------
    localparam logic [11:0] WDR_COUNT_CONTROL_OFFSET = 12'h0d8;
    localparam logic [7:0] WDR_COUNT_CONTROL_RESET = 8'hfe;
    localparam int WDR_ENABLE_BIT = 0;
    localparam int WDR_RESET_MSB_BIT = 1;
    localparam int WDR_COUNT_LSB_POS = 2;

    // ---------------------------------------------------------------
    // Timing
    // ---------------------------------------------------------------
    localparam int WDR_CLOCK_HZ = 20000000;
    localparam int WDR_DECREMENT_CYCLES = 3072;
    localparam logic [11:0] WDR_PRESCALE_LAST = 12'hbff;
    localparam int WDR_RESET_PULSE_NS = 500;
    localparam int WDR_RESET_PULSE_CYCLES = (WDR_RESET_PULSE_NS * (WDR_CLOCK_HZ / 1000000)) / 1000;
    localparam logic [3:0] WDR_PULSE_LAST = 4'(WDR_RESET_PULSE_CYCLES - 1);

    // ---------------------------------------------------------------
    // APB request carrier
    // ---------------------------------------------------------------
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } wdr_apb_req_type;

    typedef enum logic [0:0] {
        WDR_RUN = 1'b0,
        WDR_PULSE = 1'b1
    } wdr_state_type;

endpackage : wdr_pkg

`default_nettype wire

// File: hdl/wdr_watchdog_reset_timer.sv
// Watchdog reset timer with APB register access
//
// Contract
// - Activation mode comes from the sampled option input, not the register.
// - Hardware activation: active from reset, enable bit forced high.
// - Hardware activation: enable bit read value is not guaranteed.
// - Software activation: off after reset, set by writing one, cleared only by reset.
// - Seven-bit counter decrements once every 3072 clock cycles.
// - Timeout is programmable in 64 steps of 3072 cycles.
// - Active and reset bit zero: drive reset low for 500 ns.
// - Enabled and software clears the reset bit: reset immediately.
// - Count bits sit reversed in bits 7..2, bit 7 is the LSB.
// - Disabled: counter runs as a plain 7-bit timer, no reset.
// - Register resets to 1111 1110.
//
// Implementation choice: register access over APB.
`default_nettype none

module wdr_watchdog_reset_timer
(
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_hw_activation_option,
    input wire wdr_pkg::wdr_apb_req_type i_apb,
    output logic o_pready,
    output logic o_pslverr,
    output logic [31:0] o_prdata,
    output logic o_reset_n,
    output logic o_reset_n_oe
);
    import wdr_pkg::*;

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    logic [6:0] count_reg;
    logic [6:0] count_next;
    logic enable_reg;
    logic enable_next;
    logic hw_opt_reg;
    logic opt_taken_reg;
    logic [11:0] prescale_reg;
    logic [11:0] prescale_next;
    logic [3:0] pulse_reg;
    logic [3:0] pulse_next;
    wdr_state_type state_reg;
    wdr_state_type state_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;

    // ---------------------------------------------------------------
    // Bus decode
    // ---------------------------------------------------------------
    wire logic access_phase = i_apb.psel & i_apb.penable;
    wire logic hit = (i_apb.paddr == WDR_COUNT_CONTROL_OFFSET);
    wire logic wr_hit = access_phase & i_apb.pwrite & hit;
    wire logic rd_phase = i_apb.psel & ~i_apb.penable & ~i_apb.pwrite;
    wire logic [7:0] wbyte = i_apb.pwdata[7:0];
    wire logic tick = (prescale_reg == WDR_PRESCALE_LAST);
    wire logic active = enable_reg | hw_opt_reg;
    wire logic [7:0] reg_view;
    wire logic [5:0] wr_count;

    // Count bits reversed between register and counter
    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++)
        begin : g_rev
            assign reg_view[7 - gi] = count_reg[gi];
            assign wr_count[gi] = wbyte[7 - gi];
        end
    endgenerate
    assign reg_view[WDR_RESET_MSB_BIT] = count_reg[6];
    assign reg_view[WDR_ENABLE_BIT] = active;

    // ---------------------------------------------------------------
    // Next-state logic
    // ---------------------------------------------------------------
    // Writes are ignored while the reset pulse is being driven
    wire logic in_pulse = (state_reg == WDR_PULSE);
    wire logic pulse_done = in_pulse & (pulse_reg == WDR_PULSE_LAST);
    wire logic load = ~in_pulse & wr_hit;
    wire logic step = ~in_pulse & ~wr_hit & tick;
    wire logic set_enable = load & wbyte[WDR_ENABLE_BIT];
    wire logic [6:0] load_value = {wbyte[WDR_RESET_MSB_BIT], wr_count};
    wire logic [31:0] read_word = hit ? {24'h000000, reg_view} : 32'h00000000;
    wire logic fire;

    // Counter: a write wins over a simultaneous decrement
    always_comb
    begin
        count_next = count_reg;
        if (pulse_done)
        begin
            count_next = WDR_COUNT_CONTROL_RESET[7:1];
        end
        else if (load)
        begin
            count_next = load_value;
        end
        else if (step)
        begin
            count_next = count_reg - 7'h01;
        end
    end

    // Reset condition judged on the value the counter is about to take
    assign fire = ~in_pulse & active & ~count_next[6];

    // Enable is sticky until the block's own reset pulse ends
    always_comb
    begin
        enable_next = enable_reg;
        if (pulse_done)
        begin
            enable_next = 1'b0;
        end
        else if (set_enable)
        begin
            enable_next = 1'b1;
        end
    end

    // Prescaler restarts on a write so a full interval follows
    always_comb
    begin
        prescale_next = prescale_reg + 12'h001;
        if (tick || load || pulse_done)
        begin
            prescale_next = 12'h000;
        end
    end

    // Pulse sequencer
    always_comb
    begin
        state_next = state_reg;
        pulse_next = pulse_reg;
        unique case (state_reg)
            WDR_RUN:
            begin
                if (fire)
                begin
                    state_next = WDR_PULSE;
                    pulse_next = 4'h0;
                end
            end
            WDR_PULSE:
            begin
                pulse_next = pulse_reg + 4'h1;
                if (pulse_done)
                begin
                    state_next = WDR_RUN;
                end
            end
        endcase
    end

    // Read data is captured in the setup phase
    always_comb
    begin
        rdata_next = rdata_reg;
        if (rd_phase)
        begin
            rdata_next = read_word;
        end
    end

    // ---------------------------------------------------------------
    // Counter, enable and prescaler registers
    // ---------------------------------------------------------------
    // Counter register
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            count_reg <= WDR_COUNT_CONTROL_RESET[7:1];
        end
        else
        begin
            count_reg <= count_next;
        end
    end

    // Enable register
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            enable_reg <= WDR_COUNT_CONTROL_RESET[0];
        end
        else
        begin
            enable_reg <= enable_next;
        end
    end

    // Prescaler register
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            prescale_reg <= 12'h000;
        end
        else
        begin
            prescale_reg <= prescale_next;
        end
    end

    // ---------------------------------------------------------------
    // Sequencer and read registers
    // ---------------------------------------------------------------
    // Pulse length counter
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            pulse_reg <= 4'h0;
        end
        else
        begin
            pulse_reg <= pulse_next;
        end
    end

    // Sequencer state
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state_reg <= WDR_RUN;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // Read data register
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            rdata_reg <= 32'h00000000;
        end
        else
        begin
            rdata_reg <= rdata_next;
        end
    end

    // ---------------------------------------------------------------
    // Option sampling
    // ---------------------------------------------------------------
    // Marks that the option has been taken after reset release
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            opt_taken_reg <= 1'b0;
        end
        else
        begin
            opt_taken_reg <= 1'b1;
        end
    end

    // Activation mode, frozen after its first sample
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            hw_opt_reg <= 1'b0;
        end
        else if (!opt_taken_reg)
        begin
            hw_opt_reg <= i_hw_activation_option;
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    assign o_pready = 1'b1;
    assign o_pslverr = access_phase & ~hit;
    assign o_prdata = rdata_reg;
    assign o_reset_n = 1'b0;
    assign o_reset_n_oe = (state_reg == WDR_PULSE);

endmodule : wdr_watchdog_reset_timer

`default_nettype wire

// File: verif/tb.sv
// Self-checking testbench for the watchdog reset timer
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import wdr_pkg::*;
    logic i_clock = 0;
    logic i_rst_n = 0;
    logic opt = 0;
    wdr_apb_req_type req = '0;
    logic pready, perr, pin, oe, es;
    logic [31:0] prd, rd;
    logic [7:0] v;
    logic [7:0] exp_q[$];
    int fails = 0;
    int num_checks = 0;
    always #25 i_clock = ~i_clock;
    wdr_watchdog_reset_timer i_dut(.i_clock(i_clock), .i_rst_n(i_rst_n), .i_hw_activation_option(opt),
        .i_apb(req), .o_pready(pready), .o_pslverr(perr), .o_prdata(prd), .o_reset_n(pin), .o_reset_n_oe(oe));
    // ----
    // Tasks
    // ----
    task chk(input string n, input logic [31:0] e, input logic [31:0] s);
        num_checks++;
        if (s !== e)
        begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    function logic [7:0] enc(input int n, input logic c);
        logic [7:0] b;
        b[1] = n[6];
        b[0] = c;
        for (int k = 0; k < 6; k++)
            b[7 - k] = n[k];
        return b;
    endfunction : enc
    task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        req <= '{1'b1, 1'b0, w, a, {24'h0, d}};
        @(posedge i_clock);
        req.penable <= 1'b1;
        @(posedge i_clock);
        while (pready !== 1'b1)
            @(posedge i_clock);
        rd = prd;
        es = perr;
        req <= '0;
        @(posedge i_clock);
    endtask : apb
    task rst(input logic o);
        i_rst_n <= 0;
        opt <= o;
        repeat (2) @(posedge i_clock);
        i_rst_n <= 1;
        repeat (2) @(posedge i_clock);
    endtask : rst
    task pulse(input int lo, input int hi);
        int n;
        n = 0;
        #1;
        while (oe !== 1'b1 && n < hi + 2)
        begin
            @(posedge i_clock);
            #1;
            n++;
        end
        chk("pulse delay", 1, 32'(n >= lo && n <= hi));
        repeat (12) @(posedge i_clock);
    endtask : pulse
    task wrap_up;
        $display("checks %0d failures %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : wrap_up
    initial
    begin
        #2000000;
        fails++;
        wrap_up();
    end
    initial
    begin
        void'($urandom(32'h1876));
        rst(0);
        apb(1, 12'h0d4, 8'h03);
        chk("unmapped error", 1, 32'(es));
        apb(0, 12'h0d4, 8'h00);
        chk("unmapped data", 0, rd);
        apb(0, 12'h0d8, 8'h00);
        chk("reset value", 32'(WDR_COUNT_CONTROL_RESET), rd);
        repeat (4)
        begin
            v = enc(64 + $urandom_range(63), 0);
            exp_q.push_back(v);
            apb(1, 12'h0d8, v);
            apb(0, 12'h0d8, 8'h00);
            chk("readback", 32'(exp_q.pop_front()), rd);
        end
        apb(1, 12'h0d8, enc(64, 0));
        repeat (2990) @(posedge i_clock);
        apb(0, 12'h0d8, 8'h00);
        chk("before step", 32'(enc(64, 0)), rd);
        repeat (100) @(posedge i_clock);
        apb(0, 12'h0d8, 8'h00);
        chk("after step", 32'(enc(63, 0)), rd);
        v = rd[7:0];
        apb(0, 12'h0d8, 8'h00);
        chk("double read", 32'(v), rd);
        chk("timer no reset", 0, 32'(oe));
        apb(1, 12'h0d8, enc(127, 1));
        apb(1, 12'h0d8, enc(64, 0));
        pulse(3068, 3080);
        apb(0, 12'h0d8, 8'h00);
        chk("after pulse", 32'(WDR_COUNT_CONTROL_RESET), rd);
        apb(1, 12'h0d8, 8'h01);
        pulse(0, 3);
        rst(1);
        apb(0, 12'h0d8, 8'h00);
        chk("hw read", 32'h000000fe, rd & 32'hfffffffe);
        apb(1, 12'h0d8, enc(64, 0));
        pulse(3068, 3080);
        wrap_up();
    end
endmodule : tb
bind wdr_watchdog_reset_timer wdr_monitor i_mon(.i_clock(i_clock), .i_rst_n(i_rst_n), .i_apb(i_apb),
    .i_hw_activation_option(i_hw_activation_option), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .o_prdata(o_prdata), .o_reset_n(o_reset_n), .o_reset_n_oe(o_reset_n_oe));
`default_nettype wire

// File: verif/wdr_monitor.sv
// Checker for the watchdog reset timer ports
`default_nettype none
module wdr_monitor
(
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_hw_activation_option,
    input wire wdr_pkg::wdr_apb_req_type i_apb,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic [31:0] o_prdata,
    input wire logic o_reset_n,
    input wire logic o_reset_n_oe
);
    import wdr_pkg::*;
    // ----
    // Properties
    // ----
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    wire acc = i_apb.psel && i_apb.penable;
    wire hit = i_apb.paddr == WDR_COUNT_CONTROL_OFFSET;
    a_ready_high: assert property (o_pready) else $error("pready low");
    a_err_unmapped: assert property (acc && !hit |-> o_pslverr) else $error("no slave error");
    a_err_mapped: assert property (acc && hit |-> !o_pslverr) else $error("spurious error");
    a_unmapped_zero: assert property (acc && !hit && !i_apb.pwrite |-> o_prdata == 0) else $error("rdata");
    a_upper_zero: assert property (o_prdata[31:8] == 24'h0) else $error("upper rdata bits set");
    a_pin_low: assert property (!o_reset_n) else $error("reset pin value high");
    a_pulse_len: assert property ($rose(o_reset_n_oe) |=> o_reset_n_oe [*8] ##1 o_reset_n_oe ##1 !o_reset_n_oe)
        else $error("pulse");
    a_sw_reset: assert property (acc && hit && i_apb.pwrite && i_apb.pwdata[1:0] == 2'b01 && !o_reset_n_oe
        |-> ##[1:2] o_reset_n_oe) else $error("software reset missing");
endmodule : wdr_monitor
`default_nettype wire
